/* hw/dct_defines.svh */
// constants of the dual counter/timer: offsets, bit positions, resets
// assumes a 32-bit classic wishbone bus, one register per word, a byte wide except the 16-bit LCAP
`ifndef DCT_DEFINES_SVH
`define DCT_DEFINES_SVH

// ==========================================================
// register word indices (byte address = index * 4)
`define DCT_IDX_SHORT_TIMER_CONTROL     4'h0
`define DCT_IDX_SHARED_TIMER_CONTROL     4'h1
`define DCT_IDX_LONG_TIMER_CONTROL     4'h2
`define DCT_IDX_LRL      4'h3
`define DCT_IDX_LRH      4'h4
`define DCT_IDX_SRL      4'h5
`define DCT_IDX_SRH      4'h6
`define DCT_IDX_LCAP     4'h7
`define DCT_IDX_SCAP     4'h8

// ==========================================================
// bit positions in the short and long timer control registers
`define DCT_B_EN         7
`define DCT_B_SGL        6
`define DCT_B_STAT       5
`define DCT_B_CSTAT      4
`define DCT_B_CAPIE      2
`define DCT_B_IE         1

// ==========================================================
// bit positions in the shared timer control register
`define DCT_B_SDM        7
`define DCT_B_LDM        6
`define DCT_B_ESEL       4
`define DCT_B_OMODE      2
`define DCT_B_SINIT      1
`define DCT_B_LINIT      0

// ==========================================================
// reset values and timing
`define DCT_RST_BYTE     8'h00
`define DCT_RST_WORD     16'h0000
`define DCT_LONG_MAX     16'hFFFF
`define DCT_TICK_DIV     4

`endif

/* hw/dct_pkg.sv */
// types shared by the dual counter/timer modules
// assumes nothing beyond a systemverilog compiler
package dct_pkg;

  // ==========================================================
  // output mode of the shared control register
  typedef enum logic [1:0] {
    OM_NORMAL   = 2'b00,
    OM_PINGPONG = 2'b01,
    OM_FORCE_LO = 2'b10,
    OM_FORCE_HI = 2'b11
  } dct_omode_e;

  // ==========================================================
  // edge selection for the demodulation input
  typedef enum logic [1:0] {
    ES_RISE = 2'b00,
    ES_FALL = 2'b01,
    ES_BOTH = 2'b10,
    ES_ANY  = 2'b11
  } dct_esel_e;

  // ==========================================================
  // short timer demodulation states
  typedef enum logic {
    SD_WAIT = 1'b0,
    SD_RUN  = 1'b1
  } dct_sdm_e;

endpackage : dct_pkg

/* hw/dct_bus_if.sv */
// register access carrier between the bus slave and the timer core
// assumes both ends on the same clock
`timescale 1ns/1ps

interface dct_bus_if;
  logic        wr;
  logic [3:0]  idx;
  logic [7:0]  wdata;
  logic [15:0] rdata;

  modport slv  (output wr, output idx, output wdata, input rdata);
  modport core (input wr, input idx, input wdata, output rdata);
endinterface : dct_bus_if

/* hw/dct_wb.sv */
// classic wishbone slave front end for the timer registers
// assumes single cycles; every access, mapped or not, is acked
`timescale 1ns/1ps

module dct_wb
  import dct_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // wishbone
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [5:2]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // register side
  dct_bus_if.slv           bus
);

  logic        ack_r;
  logic [31:0] dat_r;
  wire         req = cyc_i & stb_i & ~ack_r;

  // ==========================================================
  // decode; only byte lane 0 carries writable bits
  assign bus.wr    = req & we_i & sel_i[0];
  assign bus.idx   = adr_i;
  assign bus.wdata = dat_i[7:0];
  assign ack_o     = ack_r;
  assign dat_o     = dat_r;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      if (req) begin
        dat_r <= {16'h0000, bus.rdata};
      end
    end
  end

endmodule : dct_wb

/* hw/dct_edge.sv */
// edge detector for the demodulation input
// assumes the pin is already synchronous to the clock
`timescale 1ns/1ps

module dct_edge
  import dct_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // pin and selection
  input  wire logic       pin,
  input  wire logic [1:0] esel,
  // selected edge seen, one cycle
  output logic            edge_p
);

  logic prev_r;
  wire  rise = pin & ~prev_r;
  wire  fall = ~pin & prev_r;

  // ==========================================================
  // edge selection; both top codes mean either edge
  assign edge_p = (esel == ES_RISE) ? rise :
                  (esel == ES_FALL) ? fall : (rise | fall);

  // previous level; reset low so a high pin looks like a rise
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= pin;
    end
  end

endmodule : dct_edge

/* hw/dct_top.sv */
// dual down counter/timer: 8-bit short and 16-bit long timer
// assumes synchronous pins and a wishbone master on CLK
// How it works
// - short demod count starts on the first selected input edge
// - each later selected edge captures the inverted short count
// - short count wrapping from zero to all-ones is no timeout
// - disabled long timer in normal or ping-pong drives inverted init level
// - output mode 10 or 11 forces long output low or high
// - long terminal count toggles output, sets status, may interrupt
// - single-pass stops at terminal count, modulo-N reloads and continues
// - reload bytes writable anytime, used only at next load
// - long demod with sticky bit ignores edges; short timeout captures it
// - writing sticky bit 0 then 1 arms one capture and reload
// - long demod counts on through all-ones, sets status, may interrupt
// - ping-pong starts when software enables either timer
// - short start in ping-pong takes init level, loads byte by level
// - terminal counts hand over between short and long, repeating
// - ping-pong terminal counts interrupt only when enabled
// - writing output mode 00 ends ping-pong
`timescale 1ns/1ps
`include "dct_defines.svh"

module dct_top
  import dct_pkg::*;
#(
  parameter int TICK_DIV = `DCT_TICK_DIV
)(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [5:2]  ADR_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  // pins
  input  wire logic        DEMOD_IN,
  output logic             SHORT_TIMER_OUTPUT,
  output logic             LONG_TIMER_OUTPUT,
  // interrupt requests
  output logic             SHORT_IRQ,
  output logic             LONG_IRQ
);

  dct_bus_if bus ();

  // ==========================================================
  // state
  logic        s_en_r, s_single_r, s_stat_r, s_ie_r, s_out_r;
  logic        l_en_r, l_single_r, l_stat_r, l_cstat_r, l_ie_r, l_capie_r;
  logic        l_lvl_r, l_arm_r, l_pin_r, s_irq_r, l_irq_r;
  logic        s_dm_r, l_dm_r, s_init_r, l_init_r;
  logic [1:0]  esel_r;
  dct_omode_e  omode_r;
  dct_sdm_e    s_dst_r;
  logic [7:0]  srl_r, srh_r, lrl_r, lrh_r, s_cnt_r, s_cap_r, div_r;
  logic [15:0] l_cnt_r, l_cap_r;
  logic        tick_r;
  logic        edge_p;

  // ==========================================================
  // submodules
  dct_wb u_wb (
    .clk   (CLK),
    .rst   (SYS_RST),
    .cyc_i (CYC_I),
    .stb_i (STB_I),
    .we_i  (WE_I),
    .sel_i (SEL_I),
    .adr_i (ADR_I),
    .dat_i (DAT_I),
    .dat_o (DAT_O),
    .ack_o (ACK_O),
    .bus   (bus.slv)
  );

  dct_edge u_edge (
    .clk    (CLK),
    .rst    (SYS_RST),
    .pin    (DEMOD_IN),
    .esel   (esel_r),
    .edge_p (edge_p)
  );

  // ==========================================================
  // write decode and register read mux
  wire [7:0]  wd    = bus.wdata;
  wire        wr0   = bus.wr & (bus.idx == `DCT_IDX_SHORT_TIMER_CONTROL);
  wire        wr1   = bus.wr & (bus.idx == `DCT_IDX_SHARED_TIMER_CONTROL);
  wire        wr2   = bus.wr & (bus.idx == `DCT_IDX_LONG_TIMER_CONTROL);
  wire [7:0]  short_timer_control  = {s_en_r, s_single_r, s_stat_r, 3'b000, s_ie_r, 1'b0};
  wire [7:0]  shared_timer_control  = {s_dm_r, l_dm_r, esel_r, omode_r, s_init_r, l_init_r};
  wire [7:0]  long_timer_control  = {l_en_r, l_single_r, l_stat_r, l_cstat_r, 1'b0,
                       l_capie_r, l_ie_r, 1'b0};
  wire [15:0] l_rel = {lrh_r, lrl_r};
  assign bus.rdata =
    (bus.idx == `DCT_IDX_SHORT_TIMER_CONTROL) ? {8'h00, short_timer_control}    :
    (bus.idx == `DCT_IDX_SHARED_TIMER_CONTROL) ? {8'h00, shared_timer_control}    :
    (bus.idx == `DCT_IDX_LONG_TIMER_CONTROL) ? {8'h00, long_timer_control}    :
    (bus.idx == `DCT_IDX_LRL)  ? {8'h00, lrl_r}   :
    (bus.idx == `DCT_IDX_LRH)  ? {8'h00, lrh_r}   :
    (bus.idx == `DCT_IDX_SRL)  ? {8'h00, srl_r}   :
    (bus.idx == `DCT_IDX_SRH)  ? {8'h00, srh_r}   :
    (bus.idx == `DCT_IDX_LCAP) ? l_cap_r          :
    (bus.idx == `DCT_IDX_SCAP) ? {8'h00, s_cap_r} : 16'h0000;

  // ==========================================================
  // timer events
  wire pp     = (omode_r == OM_PINGPONG) & ~s_dm_r & ~l_dm_r;
  wire s_zero = (s_cnt_r == 8'h00);
  wire l_zero = (l_cnt_r == 16'h0000);
  wire s_tmo  = s_en_r & ~s_dm_r & tick_r & s_zero;
  wire l_tmo  = l_en_r & ~l_dm_r & tick_r & l_zero;
  wire l_wrap = l_en_r & l_dm_r & tick_r & l_zero;
  // either enable bit starts ping-pong; handover by terminal count
  wire s_start = ~s_en_r & ((wr0 & wd[`DCT_B_EN]) | (l_tmo & pp));
  wire l_start = ~l_en_r & ((wr2 & wd[`DCT_B_EN]) | (s_tmo & pp));
  wire l_take  = l_en_r & l_dm_r & edge_p & (~l_single_r | l_arm_r);
  wire l_capev = s_tmo & l_en_r & l_dm_r & l_single_r & ~l_take;
  wire s_dmrun = s_en_r & s_dm_r & (s_dst_r == SD_RUN);

  // ==========================================================
  // timer clock enable; one pulse every TICK_DIV clocks
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      div_r  <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == 8'(TICK_DIV - 1));
      div_r  <= (div_r == 8'(TICK_DIV - 1)) ? 8'h00 : div_r + 8'h01;
    end
  end

  // configuration bits and reload bytes; reloads never touch a count
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      {s_single_r, s_ie_r, l_single_r, l_ie_r, l_capie_r} <= 5'h00;
      {s_dm_r, l_dm_r, esel_r} <= 4'h0;
      omode_r                  <= OM_NORMAL;
      {s_init_r, l_init_r}     <= 2'b00;
      {srl_r, srh_r, lrl_r, lrh_r} <= 32'h0000_0000;
    end else begin
      if (wr0) {s_single_r, s_ie_r} <= {wd[`DCT_B_SGL], wd[`DCT_B_IE]};
      // enum field split out; a packed copy would not type-check
      if (wr1) begin
        {s_dm_r, l_dm_r, esel_r} <= wd[7:4];
        omode_r                  <= dct_omode_e'(wd[3:2]);
        {s_init_r, l_init_r}     <= wd[1:0];
      end
      if (wr2) begin
        {l_single_r, l_capie_r} <= {wd[`DCT_B_SGL], wd[`DCT_B_CAPIE]};
        l_ie_r <= wd[`DCT_B_IE];
      end
      if (bus.wr && bus.idx == `DCT_IDX_SRL) srl_r <= wd;
      if (bus.wr && bus.idx == `DCT_IDX_SRH) srh_r <= wd;
      if (bus.wr && bus.idx == `DCT_IDX_LRL) lrl_r <= wd;
      if (bus.wr && bus.idx == `DCT_IDX_LRH) lrh_r <= wd;
    end
  end

  // status flags: write one clears, a same-cycle event wins
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      {s_stat_r, l_stat_r, l_cstat_r, l_arm_r} <= 4'h0;
    end else begin
      s_stat_r  <= s_tmo | (s_stat_r & ~(wr0 & wd[`DCT_B_STAT]));
      l_stat_r  <= l_tmo | l_wrap | (l_stat_r & ~(wr2 & wd[`DCT_B_STAT]));
      l_cstat_r <= l_capev | l_take | (l_cstat_r & ~(wr2 & wd[`DCT_B_CSTAT]));
      // sticky bit rewritten from 0 to 1 arms one capture
      l_arm_r   <= (wr2 & wd[`DCT_B_SGL] & ~l_single_r) | (l_arm_r & ~l_take);
    end
  end

  // short timer; demod wrap is silent, so no status there
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      {s_en_r, s_out_r} <= 2'b00;
      {s_cnt_r, s_cap_r} <= 16'h0000;
      s_dst_r <= SD_WAIT;
    end else if (s_start) begin
      s_en_r  <= 1'b1;
      s_out_r <= s_init_r;
      s_cnt_r <= (s_init_r & ~s_dm_r) ? srh_r : srl_r;
      s_dst_r <= SD_WAIT;
    end else if (wr0 && !wd[`DCT_B_EN]) begin
      s_en_r <= 1'b0;
    end else if (s_tmo) begin
      s_out_r <= ~s_out_r;
      s_cnt_r <= s_out_r ? srl_r : srh_r;
      if (s_single_r || pp) s_en_r <= 1'b0;
    end else if (s_en_r && s_dm_r) begin
      case (s_dst_r)
        SD_WAIT: begin
          if (edge_p) s_dst_r <= SD_RUN;
        end
        SD_RUN: begin
          if (edge_p) s_cap_r <= ~s_cnt_r;
          if (tick_r) s_cnt_r <= s_cnt_r - 8'h01;
        end
        default: s_dst_r <= SD_WAIT;
      endcase
    end else if (s_en_r && tick_r) begin
      s_cnt_r <= s_cnt_r - 8'h01;
    end
  end

  // long timer
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      {l_en_r, l_lvl_r} <= 2'b00;
      {l_cnt_r, l_cap_r} <= 32'h0000_0000;
    end else if (l_start) begin
      l_en_r  <= 1'b1;
      l_lvl_r <= l_init_r;
      l_cnt_r <= l_rel;
    end else if (wr2 && !wd[`DCT_B_EN]) begin
      l_en_r <= 1'b0;
      // a stop landing on terminal count still owes the toggle
      if (l_tmo && !omode_r[1]) l_lvl_r <= ~l_lvl_r;
    end else if (l_tmo) begin
      if (!omode_r[1]) l_lvl_r <= ~l_lvl_r;
      if (l_single_r || pp) l_en_r <= 1'b0;
      else l_cnt_r <= l_rel;
    end else if (l_take) begin
      l_cap_r <= l_cnt_r;
      l_cnt_r <= l_rel;
    end else begin
      if (l_capev) l_cap_r <= l_cnt_r;
      if (l_en_r && tick_r) l_cnt_r <= l_cnt_r - 16'h0001;
    end
  end

  // pins and interrupt lines, all from flops
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      {l_pin_r, s_irq_r, l_irq_r} <= 3'b000;
    end else begin
      l_pin_r <= omode_r[1] ? omode_r[0] :
                 (l_en_r ? l_lvl_r : ~l_init_r);
      s_irq_r <= s_stat_r & s_ie_r;
      l_irq_r <= (l_stat_r & l_ie_r) | (l_cstat_r & l_capie_r);
    end
  end

  assign SHORT_TIMER_OUTPUT = s_out_r;
  assign LONG_TIMER_OUTPUT  = l_pin_r;
  assign SHORT_IRQ          = s_irq_r;
  assign LONG_IRQ           = l_irq_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  AST_SDM_START: assert property (
    (s_en_r && s_dm_r && s_dst_r == SD_WAIT && edge_p && !s_start && !wr0)
    |=> s_dst_r == SD_RUN) else $error("short demod did not start");
  AST_SDM_CAP: assert property (
    (s_dmrun && edge_p && !s_start && !wr0) |=> s_cap_r == ~$past(s_cnt_r))
    else $error("short capture not inverted count");
  AST_SDM_WRAP: assert property (
    (s_dmrun && tick_r && s_zero && !s_stat_r)
    |=> !s_stat_r ##0 (s_cnt_r == 8'hFF || $past(s_start || wr0)))
    else $error("short wrap flagged as timeout");
  AST_LONG_IDLE: assert property (
    (!omode_r[1] && !l_en_r) |=> LONG_TIMER_OUTPUT == !$past(l_init_r))
    else $error("idle long output not inverted init");
  AST_LONG_FORCE: assert property (
    omode_r[1] |=> LONG_TIMER_OUTPUT == $past(omode_r[0]))
    else $error("forced long output wrong");
  AST_LONG_LOAD: assert property (
    l_start |=> l_cnt_r == $past(l_rel) && l_lvl_r == $past(l_init_r))
    else $error("long start load wrong");
  AST_LONG_TC: assert property (
    (l_tmo && !omode_r[1]) |=> l_stat_r && l_lvl_r != $past(l_lvl_r))
    else $error("long terminal count effects missing");
  AST_LONG_SGL: assert property (
    (l_tmo && l_single_r) |=> !l_en_r) else $error("single pass ran on");
  AST_LONG_MOD: assert property (
    (l_tmo && !l_single_r && !pp && !(wr2 && !wd[`DCT_B_EN]))
    |=> l_en_r && l_cnt_r == $past(l_rel))
    else $error("modulo-n reload wrong");
  AST_LONG_RUN: assert property (
    (l_en_r && !l_dm_r && tick_r && !l_zero && !wr2)
    |=> l_cnt_r == $past(l_cnt_r) - 16'h0001)
    else $error("running long count disturbed");
  AST_LONG_SCAP: assert property (
    l_capev |=> l_cap_r == $past(l_cnt_r) && l_cstat_r)
    else $error("short timeout capture missing");
  AST_LONG_ARM: assert property (
    (wr2 && wd[`DCT_B_SGL] && !l_single_r) |=> l_arm_r)
    else $error("capture not armed");
  AST_LONG_WRAP: assert property (
    (l_wrap && !l_take && !wr2) |=> l_cnt_r == `DCT_LONG_MAX && l_stat_r)
    else $error("long demod wrap wrong");
  AST_PP_START: assert property (
    (pp && !s_en_r && !l_en_r && wr0 && wd[`DCT_B_EN]) |=> s_en_r)
    else $error("ping-pong start lost");
  AST_PP_SHORT: assert property (
    s_start && !s_dm_r |=> SHORT_TIMER_OUTPUT == $past(s_init_r)
    && s_cnt_r == ($past(s_init_r) ? $past(srh_r) : $past(srl_r)))
    else $error("short start level or load wrong");
  AST_PP_HAND: assert property (
    (s_tmo && pp && !l_en_r) |=> l_en_r && !s_en_r
    && l_cnt_r == $past(l_rel) && l_lvl_r == $past(l_init_r))
    else $error("short to long handover failed");
  AST_PP_BACK: assert property (
    (l_tmo && pp && !s_en_r) |=> s_en_r && !l_en_r)
    else $error("long to short handover failed");
  AST_PP_IRQ: assert property (
    (!s_ie_r [*2]) |-> !SHORT_IRQ) else $error("masked short irq raised");
  AST_PP_END: assert property (
    (s_tmo && omode_r == OM_NORMAL && !l_en_r && !wr2) |=> !l_en_r)
    else $error("handover after ping-pong ended");

  COV_PP_CYCLE: cover property (s_tmo && pp ##[1:300] l_tmo && pp);
  COV_SDM_CAP:  cover property (s_dmrun && edge_p);
  COV_LONG_MOD: cover property (l_tmo && !l_single_r);
  COV_LONG_ARM: cover property (l_take && l_single_r);

endmodule : dct_top

/* bench/dct_far_end.sv */
// far side model: carrier burst source on the demod pin, output load
// assumes the bench clock and an active-high synchronous reset
`timescale 1ns/1ps

module dct_far_end (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // burst request: start pulse, pulse count, cycles per pulse
  input  wire logic       go,
  input  wire logic [3:0] npulse,
  input  wire logic [7:0] gap,
  output logic            pin,
  // load watching the long timer output
  input  wire logic       load_in,
  output int              toggles,
  output int              last_t,
  output int              prev_t
);
  // ==========================================================
  // carrier source
  int   now;
  int   cnt;
  int   left;
  logic seen;

  // idle low between bursts, high for the first half of each period
  always_ff @(posedge clk) begin
    now <= now + 1;
    if (rst || go) begin
      cnt  <= 0;
      left <= rst ? 0 : int'(npulse);
      pin  <= 1'b0;
    end else if (left > 0) begin
      pin <= (cnt < int'(gap) / 2);
      cnt <= (cnt == int'(gap) - 1) ? 0 : cnt + 1;
      if (cnt == int'(gap) - 1)
        left <= left - 1;
    end else
      pin <= 1'b0;
  end

  // ==========================================================
  // load: time stamps of output changes, for period checks
  always_ff @(posedge clk) begin
    seen <= load_in;
    if (!rst && seen !== load_in) begin
      toggles <= toggles + 1;
      prev_t  <= last_t;
      last_t  <= now;
    end
  end
endmodule : dct_far_end

/* bench/test_dual_counter_timer_transmit_demod.sv */
// self-checking bench of the dual counter/timer
// assumes TICK_DIV of 1, so every clock is a timer tick
`timescale 1ns/1ps
`include "dct_defines.svh"

`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("unexpected t=%0t got %0h exp %0h", $time, (g), (e)); \
  end \
end

module test_dual_counter_timer_transmit_demod
  import dct_pkg::*;
;
  // ==========================================================
  // signals
  logic        clk, rst, cyc, stb, we, dmd, go;
  logic        ack, sout, lout, sirq, lirq;
  logic [3:0]  sel, npulse;
  logic [5:2]  adr;
  logic [7:0]  gap;
  logic [31:0] dwr, drd, rv, me, mm;
  logic [31:0] exq[$];
  logic [31:0] mkq[$];
  int          toggles, last_t, prev_t, n, m, k, seed;
  int          n_mismatch, cmp_count, cycles;
  logic [7:0]  omv[4] = '{8'h00, 8'h01, {4'h0, OM_FORCE_LO, 2'h0},
                          {4'h0, OM_FORCE_HI, 2'h1}};
  logic        ome[4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  initial clk = 1'b0;
  always #5 clk = ~clk;

  dct_top #(.TICK_DIV(1)) dut (
    .CLK(clk), .SYS_RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .SEL_I(sel), .ADR_I(adr), .DAT_I(dwr), .DAT_O(drd), .ACK_O(ack),
    .DEMOD_IN(dmd), .SHORT_TIMER_OUTPUT(sout),
    .LONG_TIMER_OUTPUT(lout), .SHORT_IRQ(sirq), .LONG_IRQ(lirq));

  dct_far_end far (
    .clk(clk), .rst(rst), .go(go), .npulse(npulse), .gap(gap),
    .pin(dmd), .load_in(lout), .toggles(toggles), .last_t(last_t),
    .prev_t(prev_t));

  // ==========================================================
  // monitor: each read answer against the oldest note; hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch++;
      stop_test();
    end
    if (ack === 1'b1 && we === 1'b0 && exq.size() > 0) begin
      me = exq.pop_front();
      mm = mkq.pop_front();
      `CHK(drd & mm, me)
    end
  end

  // ==========================================================
  // tasks
  // one classic cycle; held until ack is sampled, then one idle cycle
  task automatic wb(input logic [3:0] i, input logic w,
                    input logic [7:0] d);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= i;
    dwr <= {24'h0, d};
    sel <= 4'hF;
    @(posedge clk);
    while (ack !== 1'b1 && t < 20) begin
      @(posedge clk);
      t++;
    end
    if (t == 20)
      n_mismatch++;
    rv = drd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    wb(i, 1'b1, d);
  endtask : wr

  // note the masked expectation before asking
  task automatic rd(input logic [3:0] i, input logic [31:0] e,
                    input logic [31:0] msk);
    exq.push_back(e & msk);
    mkq.push_back(msk);
    wb(i, 1'b0, 8'h00);
  endtask : rd

  task automatic burst(input logic [3:0] p);
    npulse <= p;
    go     <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (int'(gap) * int'(p) + 10) @(posedge clk);
  endtask : burst

  task automatic stop_test();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  // ==========================================================
  // main sequence
  initial begin
    seed = 3715;
    {rst, cyc, stb, we, go, sel, adr, dwr, npulse} = '0;
    rst = 1'b1;
    gap = 8'd20 + 8'($unsigned($random(seed)) % 40);
    n = 8 + $unsigned($random(seed)) % 8;
    m = n + 1 + $unsigned($random(seed)) % 6;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`DCT_IDX_SHORT_TIMER_CONTROL, 32'h0, 32'hFFFFFFFF);
    // unmapped place: reads zero, write has no effect
    rd(4'h9, 32'h0, 32'hFFFFFFFF);
    wr(4'h9, 8'hFF);
    rd(4'h9, 32'h0, 32'hFFFFFFFF);
    // idle level and forced levels of the long output
    for (int i = 0; i < 4; i++) begin
      wr(`DCT_IDX_SHARED_TIMER_CONTROL, omv[i]);
      @(posedge clk);
      `CHK(lout, ome[i])
    end
    wr(`DCT_IDX_SHARED_TIMER_CONTROL, 8'h00);
    // modulo-N: period, then a reload change taking effect only later
    wr(`DCT_IDX_LRL, 8'(n));
    wr(`DCT_IDX_LRH, 8'h00);
    k = toggles;
    wr(`DCT_IDX_LONG_TIMER_CONTROL, 8'h82);
    @(posedge clk);
    `CHK(lout, 1'b0)
    for (int t = 0; t < 200 && toggles < k + 3; t++) @(posedge clk);
    `CHK(last_t - prev_t, n + 1)
    k = toggles;
    wr(`DCT_IDX_LRL, 8'(m));
    for (int t = 0; t < 200 && toggles < k + 1; t++) @(posedge clk);
    `CHK(last_t - prev_t, n + 1)
    for (int t = 0; t < 200 && toggles < k + 2; t++) @(posedge clk);
    `CHK(last_t - prev_t, m + 1)
    `CHK(lirq, 1'b1)
    rd(`DCT_IDX_LONG_TIMER_CONTROL, 32'h20, 32'h20);
    // stop first, clear status in a second write
    wr(`DCT_IDX_LONG_TIMER_CONTROL, 8'h02);
    wr(`DCT_IDX_LONG_TIMER_CONTROL, 8'h22);
    rd(`DCT_IDX_LONG_TIMER_CONTROL, 32'h0, 32'h20);
    `CHK(lirq, 1'b0)
    `CHK(lout, 1'b1)
    // single pass: one terminal toggle, then silence
    k = toggles;
    wr(`DCT_IDX_LONG_TIMER_CONTROL, 8'hC2);
    for (int t = 0; t < 200 && toggles < k + 2; t++) @(posedge clk);
    repeat (3 * (m + 1)) @(posedge clk);
    `CHK(toggles, k + 2)
    `CHK(lirq, 1'b1)
    wr(`DCT_IDX_LONG_TIMER_CONTROL, 8'h02);
    wr(`DCT_IDX_LONG_TIMER_CONTROL, 8'h22);
    // short demod: a wrap through zero is no timeout
    wr(`DCT_IDX_SRL, 8'hFF);
    wr(`DCT_IDX_SRH, 8'hFF);
    wr(`DCT_IDX_SHARED_TIMER_CONTROL, 8'h80);
    wr(`DCT_IDX_SHORT_TIMER_CONTROL, 8'h82);
    burst(4'd1);
    repeat (300) @(posedge clk);
    rd(`DCT_IDX_SHORT_TIMER_CONTROL, 32'h0, 32'h20);
    `CHK(sirq, 1'b0)
    // restart; the second edge captures the inverted count
    wr(`DCT_IDX_SHORT_TIMER_CONTROL, 8'h00);
    wr(`DCT_IDX_SHORT_TIMER_CONTROL, 8'h20);
    wr(`DCT_IDX_SHORT_TIMER_CONTROL, 8'h82);
    burst(4'd2);
    wb(`DCT_IDX_SCAP, 1'b0, 8'h00);
    `CHK(rv[7:0] >= gap - 8'd2 && rv[7:0] <= gap + 8'd2, 1'b1)
    wr(`DCT_IDX_SHORT_TIMER_CONTROL, 8'h00);
    wr(`DCT_IDX_SHORT_TIMER_CONTROL, 8'h20);
    // ping-pong started from the short timer
    wr(`DCT_IDX_SRL, 8'h05);
    wr(`DCT_IDX_SRH, 8'h05);
    wr(`DCT_IDX_SHARED_TIMER_CONTROL, {4'h0, OM_PINGPONG, 2'h2});
    wr(`DCT_IDX_LONG_TIMER_CONTROL, 8'h42);
    k = toggles;
    wr(`DCT_IDX_SHORT_TIMER_CONTROL, 8'hC2);
    `CHK(sout, 1'b1)
    for (int t = 0; t < 100 && sirq !== 1'b1; t++) @(posedge clk);
    `CHK(sirq, 1'b1)
    `CHK(sout, 1'b0)
    for (int t = 0; t < 100 && toggles <= k; t++) @(posedge clk);
    `CHK(toggles > k, 1'b1)
    for (int t = 0; t < 100 && lirq !== 1'b1; t++) @(posedge clk);
    `CHK(lirq, 1'b1)
    wr(`DCT_IDX_SHARED_TIMER_CONTROL, 8'h00);
    // short timer still runs; its terminal count must not wake the long
    k = toggles;
    repeat (60) @(posedge clk);
    `CHK(toggles, k)
    stop_test();
  end
endmodule : test_dual_counter_timer_transmit_demod
